// ==== cdt_defs.svh ====
// register offsets, field positions, reset values and limits of the date timer
`ifndef CDT_DEFS_SVH
`define CDT_DEFS_SVH

// bus geometry
`define CDT_ADDR_W        8
`define CDT_DATA_W        32

// register byte offsets
`define CDT_OFF_CTRL      8'h00
`define CDT_OFF_ON        8'h04
`define CDT_OFF_OFF       8'h08
`define CDT_OFF_STATUS    8'h0C
`define CDT_OFF_NOW       8'h10

// control bits
`define CDT_CTRL_EN       0
`define CDT_CTRL_YEARLY   1
`define CDT_CTRL_MONTHLY  2
`define CDT_CTRL_PULSE    3
`define CDT_CTRL_W        4
`define CDT_CTRL_RST      4'h0

// status bits
`define CDT_STAT_Q        0
`define CDT_STAT_CAL_OK   1
`define CDT_STAT_CFG_OK   2
`define CDT_STAT_REJECT   3

// date word layout: day, month, year (years counted from 2000)
`define CDT_DAY_LSB       0
`define CDT_MONTH_LSB     8
`define CDT_YEAR_LSB      16
`define CDT_DAY_W         6
`define CDT_MONTH_W       4
`define CDT_YEAR_W        7

// wildcard codes for an unset field
`define CDT_WILD_DAY      6'h3F
`define CDT_WILD_MONTH    4'hF
`define CDT_WILD_YEAR     7'h7F

// calendar span 2000-01-01 .. 2099-12-31
`define CDT_YEAR_MAX      7'h63
`define CDT_MONTH_MIN     4'h1
`define CDT_MONTH_MAX     4'hC
`define CDT_DAY_MIN       6'h01
`define CDT_DAY_MAX       6'h1F

// responses
`define CDT_RESP_OKAY     2'h0
`define CDT_RESP_SLVERR   2'h2

`endif

// ==== cdt_pkg.sv ====
// types and date helpers shared by the date timer files
package cdt_pkg;
    `include "cdt_defs.svh"

    // one calendar date, year counted from 2000
    typedef struct packed {
        logic [`CDT_YEAR_W-1:0]  year;
        logic [`CDT_MONTH_W-1:0] month;
        logic [`CDT_DAY_W-1:0]   day;
    } cdt_date_s;

    // repetition and pulse selection
    typedef struct packed {
        logic pulse;
        logic monthly;
        logic yearly;
        logic en;
    } cdt_mode_s;

    typedef enum logic [0:0] {CDT_RD_IDLE, CDT_RD_DATA} cdt_rd_e;

    // field is either the wildcard or inside the 2000..2099 calendar
    function automatic logic cdt_date_ok(input cdt_date_s d);
        logic ok;
        ok = 1'b1;
        if (d.year != `CDT_WILD_YEAR && d.year > `CDT_YEAR_MAX)
            ok = 1'b0;
        if (d.month != `CDT_WILD_MONTH &&
            (d.month < `CDT_MONTH_MIN || d.month > `CDT_MONTH_MAX))
            ok = 1'b0;
        if (d.day != `CDT_WILD_DAY && (d.day < `CDT_DAY_MIN || d.day > `CDT_DAY_MAX))
            ok = 1'b0;
        return ok;
    endfunction

    function automatic cdt_date_s cdt_word_to_date(input logic [31:0] w);
        cdt_date_s d;
        d.year  = w[`CDT_YEAR_LSB +: `CDT_YEAR_W];
        d.month = w[`CDT_MONTH_LSB +: `CDT_MONTH_W];
        d.day   = w[`CDT_DAY_LSB +: `CDT_DAY_W];
        return d;
    endfunction

    function automatic logic [31:0] cdt_date_to_word(input cdt_date_s d);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`CDT_YEAR_LSB +: `CDT_YEAR_W]   = d.year;
        w[`CDT_MONTH_LSB +: `CDT_MONTH_W] = d.month;
        w[`CDT_DAY_LSB +: `CDT_DAY_W]     = d.day;
        return w;
    endfunction
endpackage

// ==== cdt_eval.sv ====
// date window evaluation: level, pulse match and configuration check
`timescale 1ns/10ps
`include "cdt_defs.svh"
module cdt_eval
    import cdt_pkg::*;
(
    // configuration
    input  wire cdt_mode_s mode,
    input  wire cdt_date_s on_date,
    input  wire cdt_date_s off_date,
    // current date
    input  wire cdt_date_s now,
    // results
    output logic           active,
    output logic           hit,
    output logic           cfg_ok
);
    logic                               in_years;
    logic [`CDT_MONTH_W+`CDT_DAY_W-1:0] on_md;
    logic [`CDT_MONTH_W+`CDT_DAY_W-1:0] off_md;
    logic [`CDT_MONTH_W+`CDT_DAY_W-1:0] now_md;
    logic                               s_oy, s_om, s_od, s_fy, s_fm, s_fd;
    logic                               m_y, m_m, m_d;

    assign m_y = (on_date.year == `CDT_WILD_YEAR) || (on_date.year == now.year);
    assign m_m = (on_date.month == `CDT_WILD_MONTH) || (on_date.month == now.month);
    assign m_d = (on_date.day == `CDT_WILD_DAY) || (on_date.day == now.day);

    // which fields are set
    assign s_oy = on_date.year != `CDT_WILD_YEAR;
    assign s_om = on_date.month != `CDT_WILD_MONTH;
    assign s_od = on_date.day != `CDT_WILD_DAY;
    assign s_fy = off_date.year != `CDT_WILD_YEAR;
    assign s_fm = off_date.month != `CDT_WILD_MONTH;
    assign s_fd = off_date.day != `CDT_WILD_DAY;

    // on year first active, off year last
    assign in_years = (now.year >= on_date.year) && (now.year <= off_date.year);
    assign on_md    = {on_date.month, on_date.day};
    assign off_md   = {off_date.month, off_date.day};
    assign now_md   = {now.month, now.day};

    // level and pulse condition for the selected mode
    always_comb begin
        active = 1'b0;
        hit    = 1'b0;
        cfg_ok = 1'b0;
        if (mode.monthly) begin
            // every month, on day to off day
            if (on_date.day <= off_date.day)
                active = in_years && now.day >= on_date.day && now.day < off_date.day;
            else
                active = in_years && (now.day >= on_date.day || now.day < off_date.day);
            // one pulse a month in the year span
            hit = in_years && m_d;
            cfg_ok = s_oy && s_od && s_fy && (mode.pulse || s_fd);
        end else if (mode.yearly) begin
            // every year, on month/day to off month/day
            if (on_md <= off_md)
                active = in_years && now_md >= on_md && now_md < off_md;
            // wrap into next year, no restart after last off
            else
                active = (now_md >= on_md && now.year >= on_date.year &&
                          now.year < off_date.year) ||
                         (now_md < off_md && now.year > on_date.year &&
                          now.year <= off_date.year);
            // off date gives only the final year
            hit    = in_years && m_m && m_d;
            cfg_ok = s_oy && s_om && s_od && s_fy && (mode.pulse || (s_fm && s_fd));
        end else begin
            // one period from full on date to full off date
            active = (now >= on_date) && (now < off_date);
            hit    = m_y && m_m && m_d;
            cfg_ok = s_oy && s_om && s_od && (mode.pulse || (s_fy && s_fm && s_fd));
        end
    end
endmodule

// ==== cdt_top.sv ====
// calendar date timer with AXI4-Lite register access
`timescale 1ns/10ps
`include "cdt_defs.svh"
// Notes on behaviour
// - level output moves only when the sampled date changes day; disable or bad config clears it at any evaluation cycle
// - on/off dates outside 2000..2099 calendar are refused
// - each date is year, month, day in that order
// - monthly mode: high from on day to off day each month
// - on year is first active year, off year the last
// - yearly mode: high from on month/day to off month/day each year
// - yearly wrap spans into next year; no restart after last off
// - pulse mode: high for exactly one evaluation cycle on the on date
// - pulse combines with monthly or yearly repetition, or stands alone
// - yearly pulse uses only the off year; off month/day may be unset
// - single pulse ignores the off date entirely
// - no repetition, no pulse: high from full on to full off date
// - monthly mode allows unset month fields
module cdt_top
    import cdt_pkg::*;
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // write address channel
    input  wire logic [`CDT_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output logic                        awready,
    // write data channel
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    // write response channel
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // read address channel
    input  wire logic [`CDT_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output logic                        arready,
    // read data channel
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // calendar source and evaluation cycle
    input  wire cdt_date_s              cal_date,
    input  wire logic                   scan_tick,
    // timer output
    output logic                        timer_q
);
    // bus side registers
    logic                   awready_ff, wready_ff, bvalid_ff;
    logic                   aw_held_ff, w_held_ff;
    logic [`CDT_ADDR_W-1:0] aw_addr_ff;
    logic [31:0]            w_data_ff;
    logic [3:0]             w_strb_ff;
    logic [1:0]             bresp_ff;
    cdt_rd_e                rd_state_ff;
    logic                   arready_ff, rvalid_ff;
    logic [31:0]            rdata_ff;
    logic [1:0]             rresp_ff;
    // timer registers
    cdt_mode_s              mode_ff;
    cdt_date_s              on_ff, off_ff;
    cdt_date_s              now_ff, last_ff;
    logic                   eval_pend_ff;
    logic                   q_ff;
    logic                   reject_ff;
    // combinational
    logic                   wr_fire;
    logic [31:0]            wr_mask;
    logic [31:0]            cur_word;
    logic [31:0]            nxt_word;
    cdt_date_s              nxt_date;
    logic                   wr_ok;
    logic [31:0]            rd_word;
    logic                   rd_hit;
    logic                   active, hit, cfg_ok, cal_ok, new_day;

    // outputs straight from flops
    assign awready = awready_ff;
    assign wready  = wready_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = arready_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;
    assign timer_q = q_ff;

    // both halves of a write captured, response slot free
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

    // write address capture; ready drops until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
        end else if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            aw_addr_ff <= awaddr;
        end else if (bvalid_ff && bready) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
        end
    end

    // write data capture, independent of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            w_data_ff <= wdata;
            w_strb_ff <= wstrb;
        end else if (bvalid_ff && bready) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
        end
    end

    // byte lanes expanded to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wr_mask[gi*8 +: 8] = {8{w_strb_ff[gi]}};
        end
    endgenerate

    // merge strobed bytes into the addressed register and check it
    always_comb begin
        cur_word = 32'h0000_0000;
        wr_ok    = 1'b0;
        case (aw_addr_ff)
            `CDT_OFF_CTRL: begin
                cur_word = {28'h0000000, mode_ff};
                wr_ok    = 1'b1;
            end
            `CDT_OFF_ON:  cur_word = cdt_date_to_word(on_ff);
            `CDT_OFF_OFF: cur_word = cdt_date_to_word(off_ff);
            default:      cur_word = 32'h0000_0000;
        endcase
        nxt_word = (cur_word & ~wr_mask) | (w_data_ff & wr_mask);
        nxt_date = cdt_word_to_date(nxt_word);
        // dates only inside the calendar span
        if (aw_addr_ff == `CDT_OFF_ON || aw_addr_ff == `CDT_OFF_OFF)
            wr_ok = cdt_date_ok(nxt_date);
    end

    // write response; refused and unmapped writes answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `CDT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? `CDT_RESP_OKAY : `CDT_RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // control and date registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff <= `CDT_CTRL_RST;
            on_ff   <= {`CDT_WILD_YEAR, `CDT_WILD_MONTH, `CDT_WILD_DAY};
            off_ff  <= {`CDT_WILD_YEAR, `CDT_WILD_MONTH, `CDT_WILD_DAY};
        end else if (wr_fire && wr_ok) begin
            case (aw_addr_ff)
                `CDT_OFF_CTRL: mode_ff <= nxt_word[`CDT_CTRL_W-1:0];
                `CDT_OFF_ON:   on_ff   <= nxt_date;
                `CDT_OFF_OFF:  off_ff  <= nxt_date;
                default:       mode_ff <= mode_ff;
            endcase
        end
    end

    // sticky record of the last write outcome, cleared by a good write
    always_ff @(posedge aclk) begin
        if (!aresetn)
            reject_ff <= 1'b0;
        else if (wr_fire)
            reject_ff <= !wr_ok;
    end

    // read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (araddr)
            `CDT_OFF_CTRL:   rd_word = {28'h0000000, mode_ff};
            `CDT_OFF_ON:     rd_word = cdt_date_to_word(on_ff);
            `CDT_OFF_OFF:    rd_word = cdt_date_to_word(off_ff);
            `CDT_OFF_STATUS: rd_word = {28'h0000000, reject_ff, cfg_ok, cal_ok, q_ff};
            `CDT_OFF_NOW:    rd_word = cdt_date_to_word(now_ff);
            default:         rd_hit  = 1'b0;
        endcase
    end

    // read channel: one read in flight, data registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= CDT_RD_IDLE;
            arready_ff  <= 1'b1;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= `CDT_RESP_OKAY;
        end else begin
            case (rd_state_ff)
                CDT_RD_IDLE: begin
                    if (arvalid) begin
                        rd_state_ff <= CDT_RD_DATA;
                        arready_ff  <= 1'b0;
                        rvalid_ff   <= 1'b1;
                        rdata_ff    <= rd_word;
                        rresp_ff    <= rd_hit ? `CDT_RESP_OKAY : `CDT_RESP_SLVERR;
                    end
                end
                CDT_RD_DATA: begin
                    if (rready) begin
                        rd_state_ff <= CDT_RD_IDLE;
                        arready_ff  <= 1'b1;
                        rvalid_ff   <= 1'b0;
                    end
                end
                default: rd_state_ff <= CDT_RD_IDLE;
            endcase
        end
    end

    // sample the calendar once per evaluation cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            now_ff       <= {`CDT_WILD_YEAR, `CDT_WILD_MONTH, `CDT_WILD_DAY};
            eval_pend_ff <= 1'b0;
        end else begin
            eval_pend_ff <= scan_tick;
            if (scan_tick)
                now_ff <= cal_date;
        end
    end

    // calendar must be a full date inside the span
    assign cal_ok  = cdt_date_ok(now_ff) && now_ff.year != `CDT_WILD_YEAR &&
                     now_ff.month != `CDT_WILD_MONTH && now_ff.day != `CDT_WILD_DAY;
    // a new day (00:00) is the only point where the output can go high
    assign new_day = now_ff != last_ff;

    // date last evaluated; first scan after reset counts as a new day
    always_ff @(posedge aclk) begin
        if (!aresetn)
            last_ff <= {`CDT_WILD_YEAR, `CDT_WILD_MONTH, `CDT_WILD_DAY};
        else if (eval_pend_ff)
            last_ff <= now_ff;
    end

    cdt_eval u_eval (
        .mode     (mode_ff),
        .on_date  (on_ff),
        .off_date (off_ff),
        .now      (now_ff),
        .active   (active),
        .hit      (hit),
        .cfg_ok   (cfg_ok)
    );

    // output update, once per evaluation cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_ff <= 1'b0;
        end else if (eval_pend_ff) begin
            if (!mode_ff.en || !cfg_ok || !cal_ok)
                q_ff <= 1'b0;
            // one evaluation cycle high, then cleared
            else if (mode_ff.pulse)
                q_ff <= new_day && hit;
            // level only moves at a day change
            else if (new_day)
                q_ff <= active;
        end
    end
endmodule

// ==== cdt_top_asserts.sv ====
// bus handshake and timer output checks for the date timer
`timescale 1ns/10ps
`include "cdt_defs.svh"
module cdt_top_chk (
    // clock and reset
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // write side
    input wire logic [`CDT_ADDR_W-1:0] awaddr,
    input wire logic                   awvalid,
    input wire logic                   awready,
    input wire logic [31:0]            wdata,
    input wire logic [3:0]             wstrb,
    input wire logic                   wvalid,
    input wire logic                   wready,
    input wire logic [1:0]             bresp,
    input wire logic                   bvalid,
    input wire logic                   bready,
    // read side
    input wire logic [`CDT_ADDR_W-1:0] araddr,
    input wire logic                   arvalid,
    input wire logic                   arready,
    input wire logic [31:0]            rdata,
    input wire logic [1:0]             rresp,
    input wire logic                   rvalid,
    input wire logic                   rready,
    // timer
    input wire logic                   scan_tick,
    input wire logic                   timer_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // address and data taken at one edge, so date checks see the whole word
    logic wr_go;
    logic date_wr;
    assign wr_go   = awvalid && awready && wvalid && wready;
    assign date_wr = wr_go && (awaddr == `CDT_OFF_ON || awaddr == `CDT_OFF_OFF);

    aw_take_a: assert property (awvalid && awready |=> !awready)
        else $error("write address ready stayed high after handshake");
    // both halves land at the handshake edge, the response flop rises one edge later
    wr_answer_a: assert property (wr_go |-> ##2 bvalid)
        else $error("no write response two edges after address and data");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped or changed before bready");
    rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer missing after address handshake");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
        else $error("read data dropped or changed before rready");
    unmap_rd_a: assert property (arvalid && arready && araddr > `CDT_OFF_NOW
        |=> rresp == `CDT_RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused with zero data");
    ro_write_a: assert property (wr_go && awaddr >= `CDT_OFF_STATUS
        |-> ##2 bresp == `CDT_RESP_SLVERR)
        else $error("write to read-only or unmapped place not refused");
    year_range_a: assert property (
        date_wr && wstrb[2] && wdata[22:16] > 7'h63 && wdata[22:16] != 7'h7F
        |-> ##2 bresp == `CDT_RESP_SLVERR)
        else $error("year beyond calendar span accepted");
    day_range_a: assert property (date_wr && wstrb[0] && wdata[5:0] == 6'h00
        |-> ##2 bresp == `CDT_RESP_SLVERR)
        else $error("day zero accepted");
    q_on_scan_a: assert property (timer_q != $past(timer_q) |-> $past(scan_tick, 2))
        else $error("timer output moved without an evaluation cycle");
endmodule

bind cdt_top cdt_top_chk u_chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .scan_tick, .timer_q);

// ==== cdt_top_tb.sv ====
// self-checking bench for the calendar date timer
`timescale 1ns/10ps
`include "cdt_defs.svh"
module cdt_top_tb
    import cdt_pkg::*;
;
    localparam logic [1:0] OK = `CDT_RESP_OKAY;
    localparam logic [1:0] ER = `CDT_RESP_SLVERR;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, scan_tick, timer_q;
    logic [7:0]  awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [31:0] wdata, rdata;
    cdt_date_s   cal_date;
    int          miscompares = 0;
    int          tests_run = 0;

    cdt_top dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .cal_date, .scan_tick, .timer_q);

    // 10 MHz clock
    initial aclk = 1'b0;
    always #50 aclk = ~aclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // date word: year from 2000, month, day
    function automatic logic [31:0] dw(input int y, input int m, input int d);
        return {9'h000, 7'(y), 4'h0, 4'(m), 2'h0, 6'(d)};
    endfunction

    // one write, address and data together; bready only after bvalid, so it must hold
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && !bready)
                bready <= 1'b1;
            n++;
        end while (!(bvalid && bready) && n < 40);
        bready <= 1'b0;
        check(32'({bvalid, bresp}), 32'({1'b1, er}));
    endtask

    // one read; rready only after rvalid, so the data must hold a cycle
    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && !rready)
                rready <= 1'b1;
            n++;
        end while (!(rvalid && rready) && n < 40);
        rready <= 1'b0;
        check(32'({rvalid, rresp}), 32'({1'b1, er}));
        check(rdata, ed);
    endtask

    // one evaluation cycle; output judged once the result has landed
    task automatic sc(input int y, input int m, input int d, input int e);
        @(posedge aclk);
        cal_date  <= {7'(y), 4'(m), 6'(d)};
        scan_tick <= 1'b1;
        @(posedge aclk);
        scan_tick <= 1'b0;
        @(posedge aclk);
        #1;
        check(32'(timer_q), 32'(e));
    endtask

    task automatic cfg(input logic [31:0] c, input logic [31:0] don, input logic [31:0] doff);
        wr(`CDT_OFF_ON, don, 4'hF, OK);
        wr(`CDT_OFF_OFF, doff, 4'hF, OK);
        wr(`CDT_OFF_CTRL, c, 4'hF, OK);
    endtask

    // reset values, refusals and field order
    task automatic t_regs();
        check(32'(timer_q), 32'h0);
        rdc(`CDT_OFF_CTRL, 32'h0, OK);
        rdc(`CDT_OFF_ON, dw(127, 15, 63), OK);
        rdc(8'h14, 32'h0, ER);
        wr(`CDT_OFF_STATUS, 32'h0, 4'hF, ER);
        wr(`CDT_OFF_ON, dw(100, 6, 1), 4'hF, ER);
        wr(`CDT_OFF_ON, dw(8, 13, 1), 4'hF, ER);
        wr(`CDT_OFF_OFF, dw(8, 6, 0), 4'hF, ER);
        rdc(`CDT_OFF_STATUS, 32'h0000_0008, OK);
        rdc(`CDT_OFF_OFF, dw(127, 15, 63), OK);
        wr(`CDT_OFF_ON, dw(99, 12, 31), 4'hF, OK);
        wr(`CDT_OFF_ON, 32'h0000_0001, 4'h1, OK);
        rdc(`CDT_OFF_ON, dw(99, 12, 1), OK);
    endtask

    // plain period, day boundary, disable and the sampled date
    task automatic t_single();
        cfg(32'h1, dw(8, 6, 1), dw(8, 8, 31));
        sc(8, 5, 31, 0);
        sc(8, 6, 1, 1);
        sc(8, 6, 1, 1);
        sc(8, 7, 1, 1);
        wr(`CDT_OFF_CTRL, 32'h0, 4'hF, OK);
        sc(8, 7, 1, 0);
        wr(`CDT_OFF_CTRL, 32'h1, 4'hF, OK);
        sc(8, 8, 30, 1);
        sc(8, 8, 31, 0);
        sc(9, 1, 1, 0);
        rdc(`CDT_OFF_NOW, dw(9, 1, 1), OK);
    endtask

    // yearly span across new year, no restart after the last year
    task automatic t_yearly();
        cfg(32'h3, dw(8, 12, 15), dw(10, 1, 7));
        sc(8, 12, 14, 0);
        sc(8, 12, 15, 1);
        sc(9, 1, 6, 1);
        sc(9, 1, 7, 0);
        sc(9, 12, 15, 1);
        sc(10, 1, 7, 0);
        sc(10, 12, 15, 0);
        wr(`CDT_OFF_OFF, dw(10, 12, 20), 4'hF, OK);
        sc(10, 12, 16, 1);
        sc(10, 12, 20, 0);
    endtask

    // monthly with unset months
    task automatic t_monthly();
        cfg(32'h5, dw(8, 15, 1), dw(10, 15, 5));
        sc(7, 12, 1, 0);
        sc(9, 3, 1, 1);
        sc(9, 3, 4, 1);
        sc(9, 3, 5, 0);
        sc(10, 12, 3, 1);
        sc(11, 1, 2, 0);
    endtask

    // pulses: yearly, single, monthly
    task automatic t_pulse();
        cfg(32'hB, dw(8, 3, 15), dw(10, 15, 63));
        sc(9, 3, 15, 1);
        sc(9, 3, 15, 0);
        sc(10, 3, 15, 1);
        sc(11, 3, 15, 0);
        cfg(32'h9, dw(8, 3, 15), dw(127, 15, 63));
        sc(8, 3, 15, 1);
        sc(8, 3, 16, 0);
        sc(9, 3, 15, 0);
        cfg(32'hD, dw(8, 15, 10), dw(10, 15, 63));
        sc(9, 7, 10, 1);
        sc(9, 7, 11, 0);
        sc(9, 8, 10, 1);
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog: the run needs well under 1000 cycles
    initial begin
        #2_000_000;
        miscompares++;
        complete_run();
    end

    // time-zero values, reset for two cycles, then the scenarios
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, scan_tick} = 6'h00;
        {awaddr, araddr, awprot, arprot, wstrb} = 26'h0;
        wdata    = 32'h0;
        cal_date = 17'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_single();
        t_yearly();
        t_monthly();
        t_pulse();
        complete_run();
    end
endmodule
